/* File: logic/cbsc_sideband.v */
// Purpose: Sideband and control pin logic of a processor on a shared front side bus.
// Assumes: One system clock; every pin input is asynchronous and is synchronised first.
// Notes:   The bus clock pin is sampled and its edges are found in the system clock.
//
// Functional notes
// RL1 - Controller disabled: pin 0 becomes maskable interrupt, pin 1 nonmaskable interrupt.
// RL2 - Local interrupt controller is enabled after reset, pins keep local role.
// RL3 - Both local interrupt pins may change at any time against bus clock.
// RL4 - Lock stays asserted from first transaction start to final transaction end.
// RL5 - Priority agent takes the bus only after lock is seen deasserted.
// RL6 - Thermal alert goes active when monitor reports maximum safe temperature.
// RL7 - Power status indicator asserted only in the two deepest sleep states.
// RL8 - System holds power ok low cleanly, then raises it monotonically.
// RL9 - System should keep power ok high throughout boundary scan.
// RL10 - Bus owner drives five request command lines with transaction type.
// RL11 - Request command lines are source synchronous to address strobe zero.
// RL12 - Reset returns to known state and invalidates caches without write-back.
// RL13 - Power-on reset is held at least two milliseconds after supply and clock.
// RL14 - On seeing reset, every agent releases its bus outputs within two clocks.
// RL15 - Straps are valid with setup time before reset is deasserted.
// RL16 - Response agent drives the three response status lines.
// RL17 - Debug tool requests debug operation by asserting probe request.
// RL18 - Device reports debug readiness on probe ready.
// RL19 - Warm restart active at reset release starts the built-in self-test.
// RL20 - Every asynchronous input passes a two flip-flop synchroniser before use.
`timescale 1ns/1ps
`include "cbsc_map.vh"

module cbsc_sideband #(
    parameter POR_HOLD_CYC = `CBSC_POR_HOLD_CYC
) (
    input  wire                       i_sys_clk,
    input  wire                       i_rst_n,
    input  wire                       i_bus_clk,
    input  wire                       i_bus_reset_n,
    input  wire                       i_power_ok,
    input  wire [1:0]                 i_local_irq_pins,
    input  wire                       i_warm_restart_n,
    input  wire                       i_probe_request_n,
    input  wire                       i_lock_in_n,
    input  wire [`CBSC_RESP_W-1:0]    i_response_status_n,
    input  wire [`CBSC_STRAP_W-1:0]   i_straps,
    input  wire                       i_lic_cfg_we,
    input  wire                       i_lic_cfg_enable,
    input  wire                       i_bus_owner,
    input  wire                       i_txn_valid,
    input  wire [`CBSC_REQ_W-1:0]     i_txn_type,
    input  wire                       i_txn_lock,
    input  wire                       i_txn_last,
    input  wire                       i_temp_max,
    input  wire                       i_tcc_enable,
    input  wire [`CBSC_SLEEP_W-1:0]   i_sleep_state,
    input  wire                       i_debug_ready,
    output wire                       o_txn_ready,
    output reg  [`CBSC_REQ_W-1:0]     o_req_cmd_n,
    output reg                        o_req_cmd_oe,
    output reg                        o_address_strobe0_n,
    output reg                        o_address_strobe0_oe,
    output reg                        o_lock_out_n,
    output reg                        o_lock_oe,
    output reg  [`CBSC_RESP_W-1:0]    o_resp_status,
    output reg                        o_resp_valid,
    output reg                        o_lock_seen,
    output reg                        o_lic_enabled,
    output reg  [1:0]                 o_local_irq,
    output reg                        o_maskable_irq,
    output reg                        o_nmi,
    output reg                        o_thermal_alert_n,
    output reg                        o_tcc_active,
    output reg                        o_power_state_indicator_n,
    output reg                        o_probe_ready_n,
    output reg                        o_debug_req,
    output reg                        o_core_reset,
    output reg                        o_cache_invalidate,
    output reg                        o_builtin_self_test_start,
    output reg  [`CBSC_STRAP_W-1:0]   o_straps,
    output reg                        o_por_hold_met
);

////////////////////////////////////////////////////////////////////////////////
// Two flip-flop synchroniser for every pin input.

reg  [`CBSC_SYNC_W-1:0] sync1_q;
reg  [`CBSC_SYNC_W-1:0] sync2_q;
wire [`CBSC_SYNC_W-1:0] pins_raw;

assign pins_raw = {i_bus_clk, i_bus_reset_n, i_power_ok, i_local_irq_pins,
                   i_warm_restart_n, i_probe_request_n, i_lock_in_n,
                   i_response_status_n, i_straps};

always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
        // Reset values match the idle pin levels except bus reset, which resets low against brst_prev_q high, so one brst_enter edge follows reset.
        sync1_q <= `CBSC_SYNC_RST;
        sync2_q <= `CBSC_SYNC_RST;
    end else begin
        sync1_q <= pins_raw;                                   // [RL20] [RL3]
        sync2_q <= sync1_q;                                    // [RL20]
    end
end

wire                     bclk_s     = sync2_q[14];
wire                     brst_n_s   = sync2_q[13];
wire                     pwr_ok_s   = sync2_q[12];
wire [1:0]               irq_pins_s = sync2_q[11:10];
wire                     warm_n_s   = sync2_q[9];
wire                     dreq_n_s   = sync2_q[8];
wire                     lock_n_s   = sync2_q[7];
wire [`CBSC_RESP_W-1:0]  resp_n_s   = sync2_q[6:4];
wire [`CBSC_STRAP_W-1:0] straps_s   = sync2_q[3:0];

////////////////////////////////////////////////////////////////////////////////
// Bus clock edges and reset edges.

reg  bclk_prev_q;
reg  brst_prev_q;
wire bclk_rise = bclk_s & ~bclk_prev_q;
wire bclk_fall = ~bclk_s & bclk_prev_q;
wire brst_enter = ~brst_n_s & brst_prev_q;
wire brst_leave = brst_n_s & ~brst_prev_q;
wire bus_up = brst_n_s & pwr_ok_s;
reg  [`CBSC_POR_CNT_W-1:0] por_cnt_q;

always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
        bclk_prev_q        <= 1'b0;
        brst_prev_q        <= 1'b1;
        o_core_reset       <= 1'b1;
        o_cache_invalidate <= 1'b0;
        o_builtin_self_test_start       <= 1'b0;
        o_straps           <= {`CBSC_STRAP_W{1'b0}};
        por_cnt_q          <= {`CBSC_POR_CNT_W{1'b0}};
        o_por_hold_met     <= 1'b0;
    end else begin
        bclk_prev_q        <= bclk_s;
        brst_prev_q        <= brst_n_s;
        o_core_reset       <= ~bus_up;                         // [RL12]
        o_cache_invalidate <= brst_enter;                      // [RL12]
        o_builtin_self_test_start       <= brst_leave & ~warm_n_s;          // [RL19]
        if (brst_leave) begin
            o_straps <= straps_s;                              // [RL15]
        end
        if (!pwr_ok_s) begin
            por_cnt_q      <= {`CBSC_POR_CNT_W{1'b0}};         // [RL8]
            o_por_hold_met <= 1'b0;
        end else if (!brst_n_s) begin
            if (por_cnt_q == POR_HOLD_CYC[`CBSC_POR_CNT_W-1:0] - 1'b1) begin
                o_por_hold_met <= 1'b1;                        // [RL13]
            end else if (!o_por_hold_met) begin
                por_cnt_q <= por_cnt_q + 1'b1;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Request command, address strobe, response status and lock.

localparam ST_IDLE   = `CBSC_ST_IDLE;
localparam ST_DRIVE  = `CBSC_ST_DRIVE;
localparam ST_STROBE = `CBSC_ST_STROBE;
localparam ST_RESP   = `CBSC_ST_RESP;

reg  [1:0] state_q;
reg        last_q;
reg        lock_q;

assign o_txn_ready = (state_q == ST_IDLE) & bus_up & i_bus_owner & bclk_rise;

always @(posedge i_sys_clk) begin
    if (!i_rst_n || !bus_up) begin
        state_q              <= ST_IDLE;                       // [RL14]
        last_q               <= 1'b0;
        lock_q               <= 1'b0;
        o_req_cmd_n          <= {`CBSC_REQ_W{1'b1}};
        o_req_cmd_oe         <= 1'b0;                          // [RL14]
        o_address_strobe0_n  <= 1'b1;
        o_address_strobe0_oe <= 1'b0;
        o_lock_out_n         <= 1'b1;
        o_lock_oe            <= 1'b0;
        o_resp_status        <= {`CBSC_RESP_W{1'b0}};
        o_resp_valid         <= 1'b0;
    end else begin
        o_resp_valid <= 1'b0;
        o_lock_out_n <= ~lock_q;
        o_lock_oe    <= lock_q;                                // [RL4] [RL5]
        case (state_q)
            ST_IDLE: begin
                if (o_txn_ready && i_txn_valid) begin
                    o_req_cmd_n          <= ~i_txn_type;       // [RL10]
                    o_req_cmd_oe         <= 1'b1;
                    o_address_strobe0_oe <= 1'b1;
                    last_q               <= ~i_txn_lock | i_txn_last;
                    if (i_txn_lock) begin
                        lock_q <= 1'b1;                        // [RL4]
                    end
                    state_q <= ST_DRIVE;
                end
            end
            ST_DRIVE: begin
                if (bclk_fall) begin
                    o_address_strobe0_n <= 1'b0;               // [RL11]
                    state_q             <= ST_STROBE;
                end
            end
            ST_STROBE: begin
                if (bclk_rise) begin
                    o_address_strobe0_n  <= 1'b1;              // [RL11]
                    o_address_strobe0_oe <= 1'b0;
                    o_req_cmd_n          <= {`CBSC_REQ_W{1'b1}};
                    o_req_cmd_oe         <= 1'b0;
                    state_q              <= ST_RESP;
                end
            end
            ST_RESP: begin
                if (bclk_rise && resp_n_s != `CBSC_RESP_IDLE_N) begin
                    o_resp_status <= ~resp_n_s;                // [RL16]
                    o_resp_valid  <= 1'b1;
                    if (last_q) begin
                        lock_q <= 1'b0;                        // [RL4]
                    end
                    state_q <= ST_IDLE;
                end
            end
            default: begin
                state_q <= ST_IDLE;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Interrupt pins, thermal, power state and debug sideband.

always @(posedge i_sys_clk) begin
    if (!i_rst_n || !brst_n_s) begin
        o_lic_enabled             <= 1'b1;                     // [RL2]
        o_local_irq               <= 2'h0;
        o_maskable_irq            <= 1'b0;
        o_nmi                     <= 1'b0;
        o_thermal_alert_n         <= 1'b1;
        o_tcc_active              <= 1'b0;
        o_power_state_indicator_n <= 1'b1;
        o_probe_ready_n           <= 1'b1;
        o_debug_req               <= 1'b0;
        o_lock_seen               <= 1'b0;
    end else begin
        if (i_lic_cfg_we) begin
            o_lic_enabled <= i_lic_cfg_enable;
        end
        o_local_irq    <= o_lic_enabled ? irq_pins_s : 2'h0;   // [RL2]
        o_maskable_irq <= ~o_lic_enabled & irq_pins_s[0];      // [RL1]
        o_nmi          <= ~o_lic_enabled & irq_pins_s[1];      // [RL1]
        o_thermal_alert_n <= ~i_temp_max;                      // [RL6]
        o_tcc_active      <= i_temp_max & i_tcc_enable;        // [RL6]
        o_power_state_indicator_n <= ~((i_sleep_state == `CBSC_SLEEP_DEEP) ||
                                       (i_sleep_state == `CBSC_SLEEP_DEEPER)); // [RL7]
        o_debug_req     <= ~dreq_n_s;                          // [RL17]
        o_probe_ready_n <= ~i_debug_ready;                     // [RL18]
        o_lock_seen     <= ~lock_n_s;
    end
end

endmodule // cbsc_sideband

/* File: logic/cbsc_map.vh */
// Purpose: Constants for the front side bus sideband and control block.
// Assumes: Included by cbsc_sideband.v only.
// Notes:   Sleep state codes are the encoding used on i_sleep_state.
`ifndef CBSC_MAP_VH
`define CBSC_MAP_VH
`define CBSC_SYS_CLK_MHZ     125
`define CBSC_POR_HOLD_US     2000
`define CBSC_POR_HOLD_CYC    (`CBSC_POR_HOLD_US * `CBSC_SYS_CLK_MHZ)
`define CBSC_POR_CNT_W       18
`define CBSC_REQ_W           5
`define CBSC_RESP_W          3
`define CBSC_RESP_IDLE_N     3'h7
`define CBSC_STRAP_W         4
`define CBSC_SLEEP_W         3
`define CBSC_SLEEP_DEEP      3'h5
`define CBSC_SLEEP_DEEPER    3'h6
`define CBSC_SYNC_W          15
`define CBSC_SYNC_RST        15'h03F0
`define CBSC_ST_IDLE         2'h0
`define CBSC_ST_DRIVE        2'h1
`define CBSC_ST_STROBE       2'h2
`define CBSC_ST_RESP         2'h3
`endif

/* File: tb/cbsc_sideband_asserts.sv */
// Purpose: Port checks for the sideband block.
// Assumes: One clock domain, synchronous active-low reset.
// Notes:   Bound to every instance of the block.
`timescale 1ns/1ps
module cbsc_sideband_asserts (
    input wire       i_sys_clk, i_rst_n, i_txn_valid, i_temp_max, i_tcc_enable, i_debug_ready,
    input wire [4:0] i_txn_type, o_req_cmd_n,
    input wire [2:0] i_sleep_state,
    input wire [1:0] o_local_irq,
    input wire       o_txn_ready, o_req_cmd_oe, o_address_strobe0_n, o_address_strobe0_oe,
    input wire       o_lock_oe, o_resp_valid, o_lic_enabled, o_maskable_irq, o_nmi,
    input wire       o_thermal_alert_n, o_tcc_active, o_power_state_indicator_n,
    input wire       o_probe_ready_n, o_core_reset, o_cache_invalidate
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    ////////////////////////////////////////////////////////////////////////////////////////
    a_route_off: assert property (!o_lic_enabled [*2] |-> o_local_irq == 2'h0)
        else $error("local irq active while controller off");
    a_route_on: assert property (o_lic_enabled [*2] |-> !o_maskable_irq && !o_nmi)
        else $error("legacy irq active while controller on");
    a_lic_default: assert property ($rose(i_rst_n) |-> o_lic_enabled)
        else $error("controller not enabled after reset");
    a_alert_cause: assert property (!o_thermal_alert_n |-> $past(i_temp_max))
        else $error("thermal alert without max temperature");
    a_tcc_cause: assert property (o_tcc_active |-> $past(i_temp_max && i_tcc_enable))
        else $error("thermal control active without cause");
    a_power_deep: assert property (!o_power_state_indicator_n |->
        $past(i_sleep_state) == 3'h5 || $past(i_sleep_state) == 3'h6)
        else $error("power indicator outside deep states");
    a_bus_release: assert property (o_core_reset |->
        !(o_req_cmd_oe || o_address_strobe0_oe || o_lock_oe))
        else $error("bus outputs driven during reset");
    a_req_type: assert property (o_txn_ready && i_txn_valid |=>
        o_req_cmd_oe && o_req_cmd_n == ~$past(i_txn_type))
        else $error("request command not driven with type");
    a_strobe_req: assert property (!o_address_strobe0_n |-> o_req_cmd_oe)
        else $error("strobe without request lines");
    a_lock_span: assert property ($fell(o_lock_oe) |-> $past(o_resp_valid) || o_core_reset)
        else $error("lock dropped before final response");
    a_inval_reset: assert property (o_cache_invalidate |-> ##[0:1] o_core_reset)
        else $error("cache invalidate outside reset");
    a_probe_ready: assert property (!o_probe_ready_n |-> $past(i_debug_ready))
        else $error("probe ready without core readiness");
    c_take: cover property (o_txn_ready && i_txn_valid);
    c_lock_end: cover property ($fell(o_lock_oe));
    c_nmi: cover property (!o_lic_enabled && o_nmi);
endmodule // cbsc_sideband_asserts
bind cbsc_sideband cbsc_sideband_asserts u_chk (
    .i_sys_clk, .i_rst_n, .i_txn_valid, .i_temp_max, .i_tcc_enable, .i_debug_ready,
    .i_txn_type, .o_req_cmd_n, .i_sleep_state, .o_local_irq, .o_txn_ready, .o_req_cmd_oe,
    .o_address_strobe0_n, .o_address_strobe0_oe, .o_lock_oe, .o_resp_valid, .o_lic_enabled,
    .o_maskable_irq, .o_nmi, .o_thermal_alert_n, .o_tcc_active, .o_power_state_indicator_n,
    .o_probe_ready_n, .o_core_reset, .o_cache_invalidate
);

/* File: tb/cbsc_far_side.sv */
// Purpose: Core logic model on the far side of the bus.
// Assumes: Bus clock runs free at 125 ns.
// Notes:   Answers each request after a set number of bus clocks.
`timescale 1ns/1ps
module cbsc_far_side (
    input  wire        i_rst_n, i_strobe_n,
    input  wire  [4:0] i_req_n,
    input  wire  [3:0] i_wait,
    input  wire  [2:0] i_code,
    output logic       o_bus_clk,
    output logic [2:0] o_resp_n,
    output logic [4:0] o_cmd
);
    initial begin
        o_bus_clk = 1'h0;
        forever #62.5 o_bus_clk = ~o_bus_clk;
    end
    // Priority requests are never made, so a held lock is never broken.
    initial begin
        o_cmd = 5'h00;
        forever begin
            @(negedge i_strobe_n);
            if (i_rst_n) o_cmd = ~i_req_n;
        end
    end
    initial begin
        o_resp_n = 3'h7;
        forever begin
            @(posedge i_strobe_n);
            if (i_rst_n) begin
                repeat (i_wait) @(negedge o_bus_clk);
                @(negedge o_bus_clk);
                o_resp_n = ~i_code;
                @(negedge o_bus_clk);
                o_resp_n = 3'h7;
            end
        end
    end
endmodule // cbsc_far_side

/* File: tb/cbsc_sideband_test.sv */
// Purpose: Self-checking bench for the sideband block.
// Assumes: Inputs change at the falling clock edge.
// Notes:   Power-on hold shortened to 20 cycles.
`timescale 1ns/1ps
module cbsc_sideband_test;
    logic i_sys_clk = 0, i_rst_n = 0, i_bus_reset_n = 0, i_power_ok = 0, i_warm_restart_n = 0;
    logic i_probe_request_n = 1, i_lic_cfg_we = 0, i_lic_cfg_enable = 1, i_bus_owner = 1;
    logic i_txn_valid = 0, i_txn_lock = 0, i_txn_last = 0, i_temp_max = 0, i_tcc_enable = 0;
    logic i_debug_ready = 0, hit = 0;
    logic [1:0] i_local_irq_pins = 2'h0;
    logic [3:0] i_straps = 4'hA, resp_wait = 4'h0;
    logic [4:0] i_txn_type = 5'h00;
    logic [2:0] i_sleep_state = 3'h0, resp_code = 3'h1;
    wire i_bus_clk, i_lock_in_n, o_txn_ready, o_req_cmd_oe, o_address_strobe0_n, o_lock_oe;
    wire o_resp_valid, o_lock_seen, o_lic_enabled, o_maskable_irq, o_nmi, o_thermal_alert_n;
    wire o_tcc_active, o_power_state_indicator_n, o_probe_ready_n, o_debug_req, o_core_reset;
    wire o_cache_invalidate, o_builtin_self_test_start, o_por_hold_met, o_address_strobe0_oe, o_lock_out_n;
    wire [1:0] o_local_irq;
    wire [2:0] i_response_status_n, o_resp_status;
    wire [3:0] o_straps;
    wire [4:0] o_req_cmd_n, seen_cmd;
    int miscompares = 0, samples_checked = 0, n;
    assign i_lock_in_n = ~o_lock_oe;
    cbsc_sideband #(.POR_HOLD_CYC(20)) dut (.i_sys_clk, .i_rst_n, .i_bus_clk, .i_bus_reset_n,
        .i_power_ok, .i_local_irq_pins, .i_warm_restart_n, .i_probe_request_n, .i_lock_in_n,
        .i_response_status_n, .i_straps, .i_lic_cfg_we, .i_lic_cfg_enable, .i_bus_owner,
        .i_txn_valid, .i_txn_type, .i_txn_lock, .i_txn_last, .i_temp_max, .i_tcc_enable,
        .i_sleep_state, .i_debug_ready, .o_txn_ready, .o_req_cmd_n, .o_req_cmd_oe,
        .o_address_strobe0_n, .o_address_strobe0_oe, .o_lock_out_n, .o_lock_oe,
        .o_resp_status, .o_resp_valid, .o_lock_seen, .o_lic_enabled, .o_local_irq,
        .o_maskable_irq, .o_nmi, .o_thermal_alert_n, .o_tcc_active, .o_power_state_indicator_n,
        .o_probe_ready_n, .o_debug_req, .o_core_reset, .o_cache_invalidate, .o_builtin_self_test_start,
        .o_straps, .o_por_hold_met);
    cbsc_far_side far (.i_rst_n, .i_strobe_n(o_address_strobe0_n), .i_req_n(o_req_cmd_n),
        .i_wait(resp_wait), .i_code(resp_code), .o_bus_clk(i_bus_clk),
        .o_resp_n(i_response_status_n), .o_cmd(seen_cmd));
    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(negedge i_sys_clk);
    endtask
    task automatic end_sim;
        $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic t_boot;
        i_power_ok = 1;
        hit = 0;
        for (n = 0; n < 5; n++) begin tick(1); hit |= o_cache_invalidate; end
        chk({hit, o_por_hold_met}, 2'h2);
        tick(25);
        chk({o_por_hold_met, o_lic_enabled, o_req_cmd_oe, o_lock_oe}, 4'hC);
        hit = 0;
        i_bus_reset_n = 1;
        for (n = 0; n < 10; n++) begin tick(1); hit |= o_builtin_self_test_start; end
        chk({hit, o_straps}, 5'h1A);
        $display("test boot done");
    endtask
    task automatic t_txn(input logic [4:0] ty, input logic lk, ls, input logic [3:0] wt);
        i_txn_type = ty; i_txn_lock = lk; i_txn_last = ls; resp_wait = wt;
        resp_code = ty[2:0] | 3'h1;
        i_txn_valid = 1;
        for (n = 0; n < 40 && !o_txn_ready; n++) tick(1);
        tick(1);
        i_txn_valid = 0;
        for (n = 0; n < 200 && !o_resp_valid; n++) tick(1);
        chk({o_resp_valid, o_resp_status}, {1'h1, ty[2:0] | 3'h1});
        chk(seen_cmd, ty);
        tick(6);
        chk({o_lock_oe, o_lock_seen, ~o_lock_out_n}, {3{lk && !ls}});
        $display("test txn %h done", ty);
    endtask
    task automatic t_irq;
        i_local_irq_pins = 2'h2;
        tick(5);
        chk({o_local_irq, o_maskable_irq, o_nmi}, 4'h8);
        i_lic_cfg_enable = 0; i_lic_cfg_we = 1;
        tick(1);
        i_lic_cfg_we = 0;
        tick(5);
        chk({o_local_irq, o_maskable_irq, o_nmi}, 4'h1);
        i_local_irq_pins = 2'h1;
        tick(1);
        chk({o_local_irq, o_maskable_irq, o_nmi}, 4'h1);
        tick(4);
        chk({o_local_irq, o_maskable_irq, o_nmi}, 4'h2);
        $display("test irq done");
    endtask
    task automatic t_reset;
        hit = 0;
        i_bus_reset_n = 0;
        for (n = 0; n < 10; n++) begin tick(1); hit |= o_cache_invalidate; end
        chk({hit, o_core_reset, o_lic_enabled}, 3'h7);
        i_warm_restart_n = 1;
        tick(30);
        hit = 0;
        i_bus_reset_n = 1;
        for (n = 0; n < 10; n++) begin tick(1); hit |= o_builtin_self_test_start; end
        chk(hit, 1'h0);
        $display("test reset done");
    endtask
    task automatic t_side;
        i_temp_max = 1; i_tcc_enable = 1; i_debug_ready = 1; i_probe_request_n = 0;
        tick(5);
        chk({o_thermal_alert_n, o_tcc_active}, 2'h1);
        chk({o_probe_ready_n, o_debug_req}, 2'h1);
        for (int c = 0; c < 8; c++) begin
            i_sleep_state = c[2:0];
            tick(5);
            chk(o_power_state_indicator_n, !(c == 5 || c == 6));
        end
        i_temp_max = 0;
        tick(5);
        chk({o_thermal_alert_n, o_tcc_active}, 2'h2);
        i_bus_owner = 0;
        hit = 0;
        for (n = 0; n < 20; n++) begin tick(1); hit |= o_txn_ready; end
        chk(hit, 1'h0);
        i_bus_owner = 1;
        $display("test side done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #4 i_sys_clk = ~i_sys_clk;
    end
    initial begin
        tick(12);
        i_rst_n = 1;
        t_boot;
        t_txn(5'h03, 1'h0, 1'h0, 4'h0);
        t_txn(5'h16, 1'h1, 1'h0, 4'h3);
        t_txn(5'h1D, 1'h1, 1'h1, 4'h1);
        t_txn(5'h08, 1'h0, 1'h0, 4'h0);
        t_irq;
        t_reset;
        t_side;
        end_sim;
    end
    initial begin
        #100000;
        miscompares++;
        end_sim;
    end
endmodule // cbsc_sideband_test
